// ==== logic/repeater_port_intrusion_guard.sv ====
// Design decisions made here: strobed register access and the placing of the registers.
`include "guard_map.svh"

module repeater_port_intrusion_guard #(
  parameter int  NPORTS       = 16,
  parameter int  BLINK_CYCLES = `GUARD_BLINK_MS * 1000000 / `GUARD_CLK_PERIOD_NS,
  localparam int PW           = $clog2(NPORTS)
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // Register port
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [31:0]                reg_rdata,
  // Received frame sources
  input  wire logic                  rx_valid,
  input  wire logic [PW-1:0]         rx_port,
  input  wire guard_pkg::station_addr_t rx_src,
  // Forwarding decision
  input  wire logic                  fwd_valid,
  input  wire guard_pkg::station_addr_t fwd_dst,
  output logic                       fwd_mask_valid,
  output logic [NPORTS-1:0]          fwd_port_mask,
  // Link status pins
  input  wire logic [NPORTS-1:0]     partition_pin,
  input  wire logic [NPORTS-1:0]     polarity_rev_pin,
  // Management access events
  input  wire logic                  mgmt_valid,
  input  wire logic                  mgmt_write,
  input  wire logic                  mgmt_listed,
  input  wire logic                  mgmt_community_ok,
  input  wire guard_pkg::station_addr_t mgmt_src,
  // Indicators and alarms
  output logic                       guard_led,
  output logic [NPORTS-1:0]          port_led,
  output logic [NPORTS-1:0]          port_off,
  output logic                       port_alarm,
  output logic                       mgmt_alarm
);
  import guard_pkg::*;

  if (NPORTS < 2 || NPORTS > 16)
  begin : g_bad_ports
    $error("NPORTS must be 2 to 16");
  end
  if (BLINK_CYCLES < 1 || BLINK_CYCLES >= (1 << 24))
  begin : g_bad_blink
    $error("BLINK_CYCLES out of range");
  end

  function automatic logic addr_eq(input station_addr_t a, input station_addr_t b);
    return a == b;
  endfunction

  guard_method_t method_q [NPORTS];
  logic [NPORTS-1:0] alarm_q;
  logic [NPORTS-1:0] eaves_q;
  station_addr_t     auth_q [NPORTS];
  logic [NPORTS-1:0] auth_valid_q;
  station_addr_t     intr_q [NPORTS];
  logic [NPORTS-1:0] viol_q;
  logic [NPORTS-1:0] viol_dis_q;
  logic [NPORTS-1:0] cmd_off_q;
  logic [PW-1:0]     sel_q;
  logic              list_default_q;
  logic [31:0]       stage_lo_q;
  logic              mgmt_viol_q;
  station_addr_t     mgmt_addr_q;
  logic [NPORTS-1:0] part_s1_q, part_s2_q, part_s3_q, part_q;
  logic [NPORTS-1:0] rev_s1_q, rev_s2_q, rev_s3_q, rev_q;
  logic [23:0]       blink_cnt_q;
  logic              blink_q;

  logic [NPORTS-1:0] guard_en;
  logic [NPORTS-1:0] autodis;
  logic [NPORTS-1:0] off_now;
  port_state_t       pstate [NPORTS];

  // Software decode
  logic wr_ctrl, wr_sel, wr_cfg, wr_alo, wr_ahi, wr_pcmd, wr_bulk;
  logic rearm, all_off;

  assign wr_ctrl = reg_wr && reg_addr == `GUARD_REG_CTRL;
  assign wr_sel  = reg_wr && reg_addr == `GUARD_REG_SEL;
  assign wr_cfg  = reg_wr && reg_addr == `GUARD_REG_CFG;
  assign wr_alo  = reg_wr && reg_addr == `GUARD_REG_AUTH_LO;
  assign wr_ahi  = reg_wr && reg_addr == `GUARD_REG_AUTH_HI;
  assign wr_pcmd = reg_wr && reg_addr == `GUARD_REG_PORTCMD;
  assign wr_bulk = reg_wr && reg_addr == `GUARD_REG_BULK;
  assign rearm   = wr_ctrl && reg_wdata[`CTRL_REARM];
  assign all_off = wr_ctrl && reg_wdata[`CTRL_ALL_OFF];

  // Derived per-port flags
  always_comb
  begin
    for (int i = 0; i < NPORTS; i++)
    begin
      guard_en[i] = alarm_q[i] || eaves_q[i];
      autodis[i]  = (method_q[i] == METH_FIRST || method_q[i] == METH_ASSIGN)
                    && guard_en[i];
      off_now[i]  = cmd_off_q[i] || viol_dis_q[i];
      if (off_now[i])
        pstate[i] = PST_OFF;
      else if (part_q[i])
        pstate[i] = PST_PART;
      else if (rev_q[i])
        pstate[i] = PST_ON_REV;
      else
        pstate[i] = PST_ON;
    end
  end

  // Receive evaluation
  logic          rx_hit;
  logic          rx_match;
  logic          rx_learn;
  logic          rx_intrude;
  guard_method_t rx_meth;

  assign rx_hit   = rx_valid && (32'(rx_port) < NPORTS);
  assign rx_meth  = method_q[rx_port];
  assign rx_match = auth_valid_q[rx_port] && addr_eq(rx_src, auth_q[rx_port]);
  assign rx_learn = rx_hit && ((rx_meth == METH_CONT && !rx_match)
                    || (rx_meth == METH_FIRST && !auth_valid_q[rx_port]));
  assign rx_intrude = rx_hit && auth_valid_q[rx_port] && !rx_match
                      && rx_meth != METH_OFF
                      && (alarm_q[rx_port] || autodis[rx_port]);

  // Control and selection
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      list_default_q <= `CTRL_LIST_DEFAULT_RST;
      sel_q          <= '0;
    end
    else
    begin
      if (wr_ctrl)
        list_default_q <= reg_wdata[`CTRL_LIST_DEFAULT];
      if (wr_sel)
        sel_q <= reg_wdata[PW-1:0];
    end
  end

  // Method and guard settings
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NPORTS; i++)
        method_q[i] <= METH_CONT;
      alarm_q <= '0;
      eaves_q <= '0;
    end
    else
    begin
      for (int i = 0; i < NPORTS; i++)
      begin
        if (all_off)
        begin
          alarm_q[i] <= 1'b0;
          eaves_q[i] <= 1'b0;
        end
        else if (wr_cfg && sel_q == PW'(i))
        begin
          method_q[i] <= guard_method_t'(reg_wdata[`CFG_METHOD_LSB +: 2]);
          // Off method drops both settings so auto-disable follows
          alarm_q[i]  <= reg_wdata[`CFG_ALARM] &&
                         guard_method_t'(reg_wdata[`CFG_METHOD_LSB +: 2]) != METH_OFF;
          eaves_q[i]  <= reg_wdata[`CFG_EAVES] &&
                         guard_method_t'(reg_wdata[`CFG_METHOD_LSB +: 2]) != METH_OFF;
        end
        else if (wr_bulk && reg_wdata[`BULK_MASK_LSB + i])
        begin
          if (!reg_wdata[`BULK_KEEP])
            method_q[i] <= guard_method_t'(reg_wdata[`BULK_METHOD_LSB +: 2]);
          alarm_q[i] <= reg_wdata[`BULK_ALARM];
          eaves_q[i] <= reg_wdata[`BULK_EAVES];
        end
      end
    end
  end

  // Authorized addresses
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NPORTS; i++)
        auth_q[i] <= '0;
      auth_valid_q <= '0;
      stage_lo_q   <= '0;
    end
    else
    begin
      if (wr_alo)
        stage_lo_q <= reg_wdata;
      for (int i = 0; i < NPORTS; i++)
      begin
        // Software write beats learning in the same cycle
        if (wr_ahi && sel_q == PW'(i))
        begin
          auth_q[i]       <= {reg_wdata[15:0], stage_lo_q};
          auth_valid_q[i] <= 1'b1;
        end
        else if (rx_learn && rx_port == PW'(i))
        begin
          auth_q[i]       <= rx_src;
          auth_valid_q[i] <= 1'b1;
        end
      end
    end
  end

  // Port violations and disable state
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NPORTS; i++)
        intr_q[i] <= '0;
      viol_q     <= '0;
      viol_dis_q <= '0;
      cmd_off_q  <= '0;
      port_alarm <= 1'b0;
    end
    else
    begin
      port_alarm <= rx_intrude && alarm_q[rx_port];
      for (int i = 0; i < NPORTS; i++)
      begin
        if (wr_pcmd && sel_q == PW'(i))
        begin
          if (reg_wdata[`PORTCMD_ENABLE])
          begin
            cmd_off_q[i]  <= 1'b0;
            viol_dis_q[i] <= 1'b0;
          end
          else if (reg_wdata[`PORTCMD_DISABLE])
            cmd_off_q[i] <= 1'b1;
        end
        if (rearm)
          viol_q[i] <= 1'b0;
        // New intrusion wins over rearm or enable in the same cycle
        if (rx_intrude && rx_port == PW'(i))
        begin
          viol_q[i] <= 1'b1;
          intr_q[i] <= rx_src;
          if (autodis[i])
            viol_dis_q[i] <= 1'b1;
        end
      end
    end
  end

  // Management access violations
  logic mgmt_raise;

  assign mgmt_raise = mgmt_valid && !list_default_q
                      && ((mgmt_write && !mgmt_listed) || !mgmt_community_ok);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mgmt_viol_q <= 1'b0;
      mgmt_addr_q <= '0;
      mgmt_alarm  <= 1'b0;
    end
    else
    begin
      mgmt_alarm <= mgmt_raise;
      if (mgmt_raise)
      begin
        mgmt_viol_q <= 1'b1;
        mgmt_addr_q <= mgmt_src;
      end
      else if (rearm)
        mgmt_viol_q <= 1'b0;
    end
  end

  // Pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      part_s1_q <= '0;
      part_s2_q <= '0;
      part_s3_q <= '0;
      part_q    <= '0;
      rev_s1_q  <= '0;
      rev_s2_q  <= '0;
      rev_s3_q  <= '0;
      rev_q     <= '0;
    end
    else
    begin
      part_s1_q <= partition_pin;
      part_s2_q <= part_s1_q;
      part_s3_q <= part_s2_q;
      rev_s1_q  <= polarity_rev_pin;
      rev_s2_q  <= rev_s1_q;
      rev_s3_q  <= rev_s2_q;
      for (int i = 0; i < NPORTS; i++)
      begin
        if (part_s2_q[i] == part_s3_q[i])
          part_q[i] <= part_s3_q[i];
        if (rev_s2_q[i] == rev_s3_q[i])
          rev_q[i] <= rev_s3_q[i];
      end
    end
  end

  // Forwarding mask, one cycle after the request
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fwd_mask_valid <= 1'b0;
      fwd_port_mask  <= '0;
    end
    else
    begin
      fwd_mask_valid <= fwd_valid;
      for (int i = 0; i < NPORTS; i++)
      begin
        if (eaves_q[i])
          fwd_port_mask[i] <= fwd_valid && !off_now[i] && auth_valid_q[i]
                              && addr_eq(fwd_dst, auth_q[i]);
        else
          fwd_port_mask[i] <= fwd_valid && !off_now[i];
      end
    end
  end

  // Blink timebase and indicators
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      blink_cnt_q <= '0;
      blink_q     <= 1'b0;
      guard_led   <= 1'b0;
      port_led    <= '0;
      port_off    <= '0;
    end
    else
    begin
      if (blink_cnt_q == 24'(BLINK_CYCLES - 1))
      begin
        blink_cnt_q <= '0;
        blink_q     <= !blink_q;
      end
      else
        blink_cnt_q <= blink_cnt_q + 24'h000001;
      // Shared and port indicators share one phase so they flash together
      guard_led <= blink_q && (|viol_q || mgmt_viol_q);
      port_led  <= blink_q ? viol_q : '0;
      port_off  <= off_now;
    end
  end

  // Read mux
  logic [31:0] rd_d;
  logic [31:0] cfg_word;
  logic [31:0] stat_word;

  always_comb
  begin
    cfg_word = '0;
    cfg_word[`CFG_METHOD_LSB +: 2] = method_q[sel_q];
    cfg_word[`CFG_ALARM]      = alarm_q[sel_q];
    cfg_word[`CFG_EAVES]      = eaves_q[sel_q];
    cfg_word[`CFG_AUTODIS]    = autodis[sel_q];
    cfg_word[`CFG_AUTH_VALID] = auth_valid_q[sel_q];
    cfg_word[`CFG_VIOL]       = viol_q[sel_q];
    cfg_word[`CFG_VIOL_DIS]   = viol_dis_q[sel_q];
    cfg_word[`CFG_CMD_OFF]    = cmd_off_q[sel_q];
    cfg_word[`CFG_STATE_LSB +: 2] = pstate[sel_q];
    stat_word = '0;
    stat_word[`STATUS_MGMT_VIOL] = mgmt_viol_q;
    stat_word[`STATUS_PORT_LSB +: NPORTS] = viol_q;
    unique case (reg_addr)
      `GUARD_REG_CTRL:    rd_d = {31'h00000000, list_default_q};
      `GUARD_REG_SEL:     rd_d = 32'(sel_q);
      `GUARD_REG_CFG:     rd_d = cfg_word;
      `GUARD_REG_AUTH_LO: rd_d = auth_q[sel_q][31:0];
      `GUARD_REG_AUTH_HI: rd_d = {16'h0000, auth_q[sel_q][47:32]};
      `GUARD_REG_INTR_LO: rd_d = intr_q[sel_q][31:0];
      `GUARD_REG_INTR_HI: rd_d = {16'h0000, intr_q[sel_q][47:32]};
      `GUARD_REG_MGMT_LO: rd_d = mgmt_addr_q[31:0];
      `GUARD_REG_MGMT_HI: rd_d = {16'h0000, mgmt_addr_q[47:32]};
      `GUARD_REG_STATUS:  rd_d = stat_word;
      default:            rd_d = '0;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= '0;
    else
      reg_rdata <= reg_rd ? rd_d : '0;
  end
endmodule

// ==== shared/guard_map.svh ====
`ifndef GUARD_MAP_SVH
`define GUARD_MAP_SVH

// Register byte addresses
`define GUARD_REG_CTRL     8'h00
`define GUARD_REG_SEL      8'h04
`define GUARD_REG_CFG      8'h08
`define GUARD_REG_AUTH_LO  8'h0C
`define GUARD_REG_AUTH_HI  8'h10
`define GUARD_REG_INTR_LO  8'h14
`define GUARD_REG_INTR_HI  8'h18
`define GUARD_REG_PORTCMD  8'h1C
`define GUARD_REG_BULK     8'h20
`define GUARD_REG_MGMT_LO  8'h24
`define GUARD_REG_MGMT_HI  8'h28
`define GUARD_REG_STATUS   8'h2C

// Field positions
`define CTRL_LIST_DEFAULT  0
`define CTRL_REARM         1
`define CTRL_ALL_OFF       2
`define CFG_METHOD_LSB     0
`define CFG_ALARM          2
`define CFG_EAVES          3
`define CFG_AUTODIS        4
`define CFG_AUTH_VALID     5
`define CFG_VIOL           6
`define CFG_VIOL_DIS       7
`define CFG_CMD_OFF        8
`define CFG_STATE_LSB      9
`define PORTCMD_ENABLE     0
`define PORTCMD_DISABLE    1
`define BULK_METHOD_LSB    0
`define BULK_KEEP          2
`define BULK_ALARM         3
`define BULK_EAVES         4
`define BULK_MASK_LSB      16
`define STATUS_MGMT_VIOL   0
`define STATUS_PORT_LSB    16

// Reset values and timing
`define CTRL_LIST_DEFAULT_RST 1'b1
`define GUARD_CLK_PERIOD_NS   25
`define GUARD_BLINK_MS        250
`endif

// ==== shared/guard_pkg.sv ====
package guard_pkg;
  typedef logic [47:0] station_addr_t;

  typedef enum logic [1:0]
  {
    METH_CONT   = 2'b00,
    METH_FIRST  = 2'b01,
    METH_ASSIGN = 2'b10,
    METH_OFF    = 2'b11
  } guard_method_t;

  typedef enum logic [1:0]
  {
    PST_ON     = 2'b00,
    PST_OFF    = 2'b01,
    PST_PART   = 2'b10,
    PST_ON_REV = 2'b11
  } port_state_t;
endpackage

// ==== verification/guard_monitor.sv ====
module guard_monitor #(
  parameter int NPORTS = 16
) (
  // Clock and register port
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic [7:0]        reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  // Events and outputs
  input wire logic              rx_valid,
  input wire logic              fwd_valid,
  input wire logic              fwd_mask_valid,
  input wire logic [NPORTS-1:0] fwd_port_mask,
  input wire logic              mgmt_valid,
  input wire logic              mgmt_write,
  input wire logic              mgmt_listed,
  input wire logic              mgmt_community_ok,
  input wire logic              guard_led,
  input wire logic [NPORTS-1:0] port_led,
  input wire logic [NPORTS-1:0] port_off,
  input wire logic              port_alarm,
  input wire logic              mgmt_alarm
);
  timeunit 1ns;
  timeprecision 100ps;
  logic en_q;
  logic en_qq;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // Port off may lag its enable write by one or two cycles
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_q  <= 1'b0;
      en_qq <= 1'b0;
    end
    else
    begin
      en_q  <= reg_wr && reg_addr == 8'h1C && reg_wdata[0];
      en_qq <= en_q;
    end
  end

  sequence s_rearm;
    reg_wr && reg_addr == 8'h00 && reg_wdata[1] && !rx_valid && !mgmt_valid;
  endsequence
  sequence s_quiet;
    !rx_valid && !mgmt_valid;
  endsequence

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_fwd_pulse: assert property (fwd_mask_valid == $past(fwd_valid))
    else $error("forward answer not one cycle after query");
  a_fwd_zero: assert property (!fwd_mask_valid |-> fwd_port_mask == '0)
    else $error("forward mask outside its cycle");
  a_mgmt_cause: assert property (mgmt_alarm |-> $past(mgmt_valid) &&
      (($past(mgmt_write) && !$past(mgmt_listed)) || !$past(mgmt_community_ok)))
    else $error("management alarm without cause");
  a_alarm_cause: assert property (port_alarm |-> $past(rx_valid))
    else $error("port alarm without frame");
  a_led_pair: assert property (|port_led |-> guard_led)
    else $error("port indicator without guard indicator");
  a_off_release: assert property ($past(rst_n) && |($past(port_off) & ~port_off)
      |-> en_q || en_qq)
    else $error("port re-enabled without enable command");
  a_rearm_dark: assert property (s_rearm ##1 s_quiet |=> !guard_led && port_led == '0)
    else $error("indicators lit after rearm");
endmodule

// ==== verification/repeater_port_intrusion_guard_tb.sv ====
module repeater_port_intrusion_guard_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import guard_pkg::*;

  localparam station_addr_t A = 48'hA0A0_0000_0001;
  localparam station_addr_t B = 48'hB0B0_0000_0002;
  localparam station_addr_t C = 48'hC0C0_0000_0003;
  localparam station_addr_t D = 48'hD0D0_0000_0004;

  logic          sys_clk = 1'b0;
  logic          rst_n = 1'b0;
  logic [7:0]    reg_addr = 8'h00;
  logic [31:0]   reg_wdata = 32'h0;
  logic          reg_wr = 1'b0;
  logic          reg_rd = 1'b0;
  logic [31:0]   reg_rdata;
  logic          rx_valid;
  logic [3:0]    rx_port;
  station_addr_t rx_src;
  logic          fwd_valid = 1'b0;
  station_addr_t fwd_dst = '0;
  logic          fwd_mask_valid;
  logic [15:0]   fwd_port_mask;
  logic [15:0]   partition_pin = 16'h0;
  logic [15:0]   polarity_rev_pin = 16'h0;
  logic          mgmt_valid;
  logic          mgmt_write;
  logic          mgmt_listed;
  logic          mgmt_community_ok;
  station_addr_t mgmt_src;
  logic          guard_led;
  logic [15:0]   port_led;
  logic [15:0]   port_off;
  logic          port_alarm;
  logic          mgmt_alarm;
  int            num_errors = 0;
  int            checks = 0;

  always #12.5 sys_clk = ~sys_clk;

  repeater_port_intrusion_guard #(.NPORTS(16), .BLINK_CYCLES(4)) repeater_port_intrusion_guard_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
    .rx_port(rx_port), .rx_src(rx_src), .fwd_valid(fwd_valid), .fwd_dst(fwd_dst),
    .fwd_mask_valid(fwd_mask_valid), .fwd_port_mask(fwd_port_mask),
    .partition_pin(partition_pin), .polarity_rev_pin(polarity_rev_pin),
    .mgmt_valid(mgmt_valid), .mgmt_write(mgmt_write), .mgmt_listed(mgmt_listed),
    .mgmt_community_ok(mgmt_community_ok), .mgmt_src(mgmt_src), .guard_led(guard_led),
    .port_led(port_led), .port_off(port_off), .port_alarm(port_alarm), .mgmt_alarm(mgmt_alarm));

  station_model station_model_i (
    .sys_clk(sys_clk), .rx_valid(rx_valid), .rx_port(rx_port), .rx_src(rx_src),
    .mgmt_valid(mgmt_valid), .mgmt_write(mgmt_write), .mgmt_listed(mgmt_listed),
    .mgmt_community_ok(mgmt_community_ok), .mgmt_src(mgmt_src));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  task automatic cfg_is(input logic [31:0] p, input logic [31:0] e);
    wr(8'h04, p);
    expect_reg(8'h08, e);
  endtask

  task automatic fwd(input station_addr_t dst, input logic [15:0] e);
    @(posedge sys_clk);
    fwd_valid <= 1'b1;
    fwd_dst <= dst;
    @(posedge sys_clk);
    fwd_valid <= 1'b0;
    #1;
    chk({31'h0, fwd_mask_valid}, 32'h1);
    chk({16'h0, fwd_port_mask}, {16'h0, e});
  endtask

  // Blink phase is free running, so watch a whole period and more
  task automatic led_chk(input int p, input logic e);
    logic seen;
    seen = 1'b0;
    repeat (10)
    begin
      @(posedge sys_clk);
      #1;
      seen = seen | (port_led[p] & guard_led);
    end
    chk({31'h0, seen}, {31'h0, e});
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Whole run needs about two hundred cycles
  initial
  begin
    #100us;
    num_errors++;
    conclude();
  end

  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    cfg_is(0, 32'h0);
    expect_reg(8'h00, 32'h1);
    expect_reg(8'h30, 32'h0);
    $display("reset test done");
    wr(8'h04, 2);
    wr(8'h08, 32'h5);
    cfg_is(2, 32'h15);
    station_model_i.frame(2, A);
    station_model_i.frame(2, A);
    cfg_is(2, 32'h35);
    station_model_i.frame(2, B);
    #1;
    chk({31'h0, port_alarm}, 32'h1);
    led_chk(2, 1'b1);
    expect_reg(8'h14, B[31:0]);
    expect_reg(8'h18, {16'h0, B[47:32]});
    cfg_is(2, 32'h2F5);
    chk({16'h0, port_off}, 32'h4);
    wr(8'h00, 32'h3);
    cfg_is(2, 32'h2B5);
    led_chk(2, 1'b0);
    chk({16'h0, port_off}, 32'h4);
    wr(8'h1C, 32'h1);
    cfg_is(2, 32'h35);
    station_model_i.frame(2, B);
    cfg_is(2, 32'h2F5);
    wr(8'h00, 32'h3);
    wr(8'h1C, 32'h1);
    $display("first heard test done");
    wr(8'h04, 3);
    wr(8'h08, 32'h4);
    cfg_is(3, 32'h4);
    station_model_i.frame(3, A);
    station_model_i.frame(3, B);
    cfg_is(3, 32'h64);
    expect_reg(8'h0C, B[31:0]);
    wr(8'h00, 32'h3);
    station_model_i.frame(3, B);
    cfg_is(3, 32'h24);
    $display("continuous test done");
    wr(8'h04, 4);
    wr(8'h0C, C[31:0]);
    wr(8'h10, {16'h0, C[47:32]});
    wr(8'h08, 32'hA);
    cfg_is(4, 32'h3A);
    fwd(C, 16'hFFFF);
    fwd(D, 16'hFFEF);
    station_model_i.frame(4, D);
    #1;
    chk({31'h0, port_alarm}, 32'h0);
    cfg_is(4, 32'h2FA);
    fwd(C, 16'hFFEF);
    $display("assigned test done");
    wr(8'h00, 32'h5);
    cfg_is(4, 32'h2E2);
    cfg_is(2, 32'h21);
    station_model_i.frame(2, C);
    cfg_is(2, 32'h21);
    expect_reg(8'h0C, A[31:0]);
    station_model_i.access(1'b1, 1'b0, 1'b1, A);
    #1;
    chk({31'h0, mgmt_alarm}, 32'h0);
    expect_reg(8'h2C, 32'h0010_0000);
    wr(8'h00, 32'h0);
    station_model_i.access(1'b1, 1'b0, 1'b1, C);
    #1;
    chk({31'h0, mgmt_alarm}, 32'h1);
    expect_reg(8'h2C, 32'h0010_0001);
    expect_reg(8'h24, C[31:0]);
    wr(8'h00, 32'h2);
    expect_reg(8'h2C, 32'h0);
    station_model_i.access(1'b0, 1'b1, 1'b0, D);
    expect_reg(8'h2C, 32'h1);
    $display("management test done");
    wr(8'h20, 32'h0060_0009);
    for (int p = 5; p < 8; p++)
      cfg_is(p, (p < 7) ? 32'h15 : 32'h0);
    partition_pin <= 16'h0100;
    polarity_rev_pin <= 16'h0200;
    wr(8'h04, 10);
    wr(8'h1C, 32'h2);
    repeat (4) @(posedge sys_clk);
    cfg_is(8, 32'h400);
    cfg_is(9, 32'h600);
    cfg_is(10, 32'h300);
    chk({16'h0, port_off}, 32'h0410);
    wr(8'h04, 11);
    wr(8'h08, 32'h7);
    cfg_is(11, 32'h3);
    $display("status test done");
    conclude();
  end
endmodule

bind repeater_port_intrusion_guard guard_monitor #(.NPORTS(NPORTS)) guard_monitor_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
  .fwd_valid(fwd_valid), .fwd_mask_valid(fwd_mask_valid), .fwd_port_mask(fwd_port_mask),
  .mgmt_valid(mgmt_valid), .mgmt_write(mgmt_write), .mgmt_listed(mgmt_listed),
  .mgmt_community_ok(mgmt_community_ok), .guard_led(guard_led), .port_led(port_led),
  .port_off(port_off), .port_alarm(port_alarm), .mgmt_alarm(mgmt_alarm));

// ==== verification/station_model.sv ====
module station_model (
  // Clock
  input wire logic                 sys_clk,
  // Frame sources
  output logic                     rx_valid,
  output logic [3:0]               rx_port,
  output guard_pkg::station_addr_t rx_src,
  // Management accesses
  output logic                     mgmt_valid,
  output logic                     mgmt_write,
  output logic                     mgmt_listed,
  output logic                     mgmt_community_ok,
  output guard_pkg::station_addr_t mgmt_src
);
  timeunit 1ns;
  timeprecision 100ps;
  import guard_pkg::*;

  initial
  begin
    rx_valid = 1'b0;
    rx_port = 4'h0;
    rx_src = '0;
    mgmt_valid = 1'b0;
    mgmt_write = 1'b0;
    mgmt_listed = 1'b1;
    mgmt_community_ok = 1'b1;
    mgmt_src = '0;
  end

  task automatic frame(input logic [3:0] p, input station_addr_t s);
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_port <= p;
    rx_src <= s;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    // Released bus shows no stale source
    rx_src <= ~s;
  endtask

  task automatic access(input logic w, input logic l, input logic ok, input station_addr_t s);
    @(posedge sys_clk);
    mgmt_valid <= 1'b1;
    mgmt_write <= w;
    mgmt_listed <= l;
    mgmt_community_ok <= ok;
    mgmt_src <= s;
    @(posedge sys_clk);
    mgmt_valid <= 1'b0;
    mgmt_src <= ~s;
  endtask
endmodule
